// ==== gpc_chk.sv ====
// Purpose: port checks for the pin control block. Assumes: one clock. Notes: bound by name.
`timescale 1ns/10ps
`default_nettype none
module gpc_chk (input wire i_mclk, i_rst_b, i_reg_wr, o_grp_out, o_pad_out, o_pad_oe,
  input wire o_int_invert, input wire [31:0] i_reg_wdata, o_reg_rdata,
  input wire [4:0] i_alt_out, i_alt_oe);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  wire [31:0] r = o_reg_rdata;
  sequence gp_s; r[14:12] == 3'h0; endsequence
  pin_out_a: assert property (gp_s ##0 !r[10] |-> o_pad_out == r[16]) else $error("pin");
  wr_data_a: assert property (i_reg_wr && !r[10] |=> r[16] == $past(i_reg_wdata[16]))
    else $error("data write");
  ro_data_a: assert property (i_reg_wr && r[10] |=> $stable(r[16])) else $error("ro");
  mux_keep_a: assert property (i_reg_wr && i_reg_wdata[14:13] == 2'b11 |=> $stable(r[14:12]))
    else $error("mux");
  alt_inv_a: assert property (r[14:12] == 3'h1 |->
    o_pad_out == (i_alt_out[0] ^ r[11]) && o_pad_oe == i_alt_oe[0]) else $error("alt");
  int_inv_a: assert property (o_int_invert == (r[11] && r[14:12] != 3'h0)) else $error("int");
  grp_out_a: assert property (gp_s ##0 r[10] |-> o_pad_out == o_grp_out) else $error("grp");
  resv_zero_a: assert property (r[31:25] == 7'h0 && r[23:17] == 7'h0 && r[8:0] == 9'h0)
    else $error("reserved");
endmodule // gpc_chk
bind gpc_pin_control gpc_chk chk (.*);
`default_nettype wire

// ==== gpc_defines.vh ====
// Purpose: Constants for the per-pin control register block.
// Assumes: One 32-bit control word per pin.
// Notes: Field positions follow the control word layout.
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
`define GPC_BIT_PAD_IN 24
`define GPC_BIT_OUT_DATA 16
`define GPC_BIT_IN_DIS 15
`define GPC_MUX_HI 14
`define GPC_MUX_LO 12
`define GPC_BIT_POL 11
`define GPC_BIT_OUT_SEL 10
`define GPC_BIT_DIR 9
`define GPC_MUX_GPIO 3'h0
`define GPC_MUX_ALT5 3'h5
`define GPC_RST_VALUE 32'h00000000
`endif

// ==== gpc_pad_model.sv ====
// Purpose: pad and alternate functions. Assumes: released pad follows i_ext. Notes: none.
`timescale 1ns/10ps
`default_nettype none
module gpc_pad_model (input wire i_mclk, i_out, i_oe, i_ext, output var logic o_pad,
  output var logic [9:0] o_alt = 10'h0);
  always_comb o_pad = i_oe ? i_out : i_ext;
  always @(posedge i_mclk) o_alt <= o_alt + 10'h3b5;
endmodule // gpc_pad_model
`default_nettype wire

// ==== gpc_pin_control.v ====
// Purpose: Per-pin control register and output, direction and input path.
// Assumes: Register port on the system clock, pad input from outside the clock domain.
// Notes: Bits outside the listed fields are reserved and read as zero.
// Summary of operation
// - GPIO output mode with single-bit path drives pin from output data bit.
// - Write to output data bit sets pin low or high when single-bit path enabled.
// - Grouped path selected makes output data bit read-only; writes ignored.
// - Output data bit reads back the programmed value, not the pin.
// - Input disable bit blocks the pin input path when one.
// - Three-bit function select: 0 GPIO, 1-4 alternates, 5 optional, 6-7 reserved.
// - Polarity one with alternate function inverts alternate function outputs.
// - Polarity one with alternate function inverts interrupt detection sense.
// - Polarity has no effect on the pin output in GPIO mode.
// - Grouped input register reports pin state uninverted always.
// - Pad input bit reflects pin regardless of source select; one when well off.
// - Output source select: zero single-bit path, one grouped register path.
// - Direction bit controls buffer only in GPIO mode; otherwise function does.
`timescale 1ns/10ps
`include "gpc_defines.vh"
`default_nettype none
module gpc_pin_control #(
  parameter HAS_ALT5 = 1
) (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_reg_wr,
  input wire [31:0] i_reg_wdata,
  output wire [31:0] o_reg_rdata,
  input wire i_grp_wr,
  input wire i_grp_wdata,
  output wire o_grp_out,
  output wire o_grp_in,
  input wire i_pad_in,
  input wire i_well_off,
  input wire [4:0] i_alt_out,
  input wire [4:0] i_alt_oe,
  output wire [4:0] o_alt_in,
  output wire o_pad_out,
  output wire o_pad_oe,
  output wire o_pad_in_en,
  output wire o_int_invert,
  output wire o_pad_sync
);
  // Stored fields of the control word, and the grouped output bit.
  reg out_data_reg;
  reg in_dis_reg;
  reg [2:0] mux_reg;
  reg pol_reg;
  reg out_sel_reg;
  reg dir_reg;
  reg grp_out_reg;
  // Two-stage synchroniser for the asynchronous pad level.
  reg sync1_reg;
  reg sync2_reg;
  // Next values of the stored fields.
  reg out_data_next;
  reg in_dis_next;
  reg [2:0] mux_next;
  reg pol_next;
  reg out_sel_next;
  reg dir_next;
  reg grp_out_next;
  // Decoded write data and derived controls.
  wire [2:0] wmux;
  reg mux_ok;
  reg alt_en;
  reg [4:0] alt_onehot;
  reg alt_level;
  reg alt_drive;
  reg pad_level;
  reg pad_drive;
  reg [31:0] rdata;
  wire alt_sel;
  wire gpio_level;
  wire pad_seen;
  wire pad_status;

  assign wmux = i_reg_wdata[`GPC_MUX_HI:`GPC_MUX_LO];

  always @* begin
    mux_ok = 1'b0;
    case (wmux)
      3'h0: begin
        mux_ok = 1'b1;
      end
      3'h1, 3'h2, 3'h3, 3'h4: begin
        mux_ok = 1'b1;
      end
      3'h5: begin
        mux_ok = (HAS_ALT5 != 0);
      end
      default: begin
        // Reserved codes are refused so the pin never points at a missing function.
        mux_ok = 1'b0;
      end
    endcase
  end

  always @* begin
    in_dis_next = in_dis_reg;
    mux_next = mux_reg;
    pol_next = pol_reg;
    out_sel_next = out_sel_reg;
    dir_next = dir_reg;
    out_data_next = out_data_reg;
    grp_out_next = grp_out_reg;
    if (i_reg_wr) begin
      in_dis_next = i_reg_wdata[`GPC_BIT_IN_DIS];
      pol_next = i_reg_wdata[`GPC_BIT_POL];
      out_sel_next = i_reg_wdata[`GPC_BIT_OUT_SEL];
      dir_next = i_reg_wdata[`GPC_BIT_DIR];
      if (mux_ok) begin
        mux_next = wmux;
      end
    end
    // gated data write
    // The select in force before the write decides, so one write can flip it safely.
    if (i_reg_wr && !out_sel_reg) begin
      out_data_next = i_reg_wdata[`GPC_BIT_OUT_DATA];
    end
    // Grouped bit is writable only while the grouped path is selected.
    if (i_grp_wr && out_sel_reg) begin
      grp_out_next = i_grp_wdata;
    end
  end

  always @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_data_reg <= 1'b0;
      in_dis_reg <= 1'b0;
      mux_reg <= `GPC_MUX_GPIO;
      pol_reg <= 1'b0;
      out_sel_reg <= 1'b0;
      dir_reg <= 1'b0;
      grp_out_reg <= 1'b0;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= i_pad_in;
      sync2_reg <= sync1_reg;
      out_data_reg <= out_data_next;
      in_dis_reg <= in_dis_next;
      mux_reg <= mux_next;
      pol_reg <= pol_next;
      out_sel_reg <= out_sel_next;
      dir_reg <= dir_next;
      grp_out_reg <= grp_out_next;
    end
  end

  assign pad_seen = sync2_reg & ~in_dis_reg;
  assign pad_status = pad_seen | i_well_off;
  assign o_pad_sync = pad_status;
  assign o_grp_in = pad_status;
  assign o_grp_out = grp_out_reg;
  assign o_pad_in_en = ~in_dis_reg;
  assign alt_sel = (mux_reg != `GPC_MUX_GPIO);
  assign gpio_level = out_sel_reg ? grp_out_reg : out_data_reg;

  // One-hot pick of the alternate function; no index ever leaves the port range.
  always @* begin
    alt_en = 1'b0;
    alt_onehot = 5'h00;
    case (mux_reg)
      3'h1: begin
        alt_en = 1'b1;
        alt_onehot = 5'h01;
      end
      3'h2: begin
        alt_en = 1'b1;
        alt_onehot = 5'h02;
      end
      3'h3: begin
        alt_en = 1'b1;
        alt_onehot = 5'h04;
      end
      3'h4: begin
        alt_en = 1'b1;
        alt_onehot = 5'h08;
      end
      3'h5: begin
        alt_en = 1'b1;
        alt_onehot = 5'h10;
      end
      default: begin
        alt_en = 1'b0;
        alt_onehot = 5'h00;
      end
    endcase
  end

  always @* begin
    alt_level = alt_en & ((|(i_alt_out & alt_onehot)) ^ pol_reg);
    alt_drive = |(i_alt_oe & alt_onehot);
  end

  always @* begin
    if (alt_sel) begin
      pad_level = alt_level;
      pad_drive = alt_drive;
    end else begin
      pad_level = gpio_level;
      pad_drive = dir_reg;
    end
  end

  assign o_pad_out = pad_level;
  assign o_pad_oe = pad_drive;
  assign o_alt_in = {5{pad_seen}} & alt_onehot;
  assign o_int_invert = pol_reg & alt_sel;

  always @* begin
    rdata = 32'h00000000;
    rdata[`GPC_BIT_PAD_IN] = pad_status;
    rdata[`GPC_BIT_OUT_DATA] = out_data_reg;
    rdata[`GPC_BIT_IN_DIS] = in_dis_reg;
    rdata[`GPC_MUX_HI:`GPC_MUX_LO] = mux_reg;
    rdata[`GPC_BIT_POL] = pol_reg;
    rdata[`GPC_BIT_OUT_SEL] = out_sel_reg;
    rdata[`GPC_BIT_DIR] = dir_reg;
  end

  assign o_reg_rdata = rdata;
endmodule // gpc_pin_control
`default_nettype wire

// ==== testbench.sv ====
// Purpose: random check of the pin control block. Assumes: default parameter. Notes: none.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 0, rb = 0, wr = 0, gw = 0, gd = 0, wo = 0, ex = 0, pad, po, pe;
  logic [31:0] wd = 0, rd;
  logic [9:0] alt;
  logic [7:0] s = 0;
  logic gout, gin, pen, psync, g = 0, h1 = 0, h2 = 0, e24;
  logic [4:0] ain;
  int num_errors = 0, n_checks = 0;
  always #20 clk = ~clk;
  gpc_pin_control dut (.i_mclk(clk), .i_rst_b(rb), .i_reg_wr(wr), .i_reg_wdata(wd),
    .o_reg_rdata(rd), .i_grp_wr(gw), .i_grp_wdata(gd), .o_grp_out(gout), .o_grp_in(gin),
    .i_pad_in(pad), .i_well_off(wo), .i_alt_out(alt[4:0]), .i_alt_oe(alt[9:5]),
    .o_alt_in(ain), .o_pad_out(po), .o_pad_oe(pe), .o_pad_in_en(pen), .o_int_invert(),
    .o_pad_sync(psync));
  gpc_pad_model pm (.i_mclk(clk), .i_out(po), .i_oe(pe), .i_ext(ex), .o_pad(pad), .o_alt(alt));
  function logic [7:0] nx(input logic [7:0] c, input logic [31:0] w);
    nx = w[16:9];
    if (c[1]) nx[7] = c[7];
    if (w[14:13] == 2'b11) nx[5:3] = c[5:3];
  endfunction
  function logic [4:0] ea(input logic [2:0] m, input logic b);
    ea = (m != 3'h0 && m <= 3'h5) ? (5'(b) << (m - 3'h1)) : 5'h00;
  endfunction
  task print_verdict;
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(98006));
    repeat (6) @(posedge clk);
    rb <= 1;
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      if (gw && s[1]) g = gd;
      if (wr) s = nx(s, wd);
      wr <= n < 3 || $urandom % 2;
      wd <= n == 0 ? 32'hffffffff : n == 1 ? 32'h00010200 : $urandom;
      {gw, gd, wo, ex} <= 4'($urandom);
      #1 n_checks++;
      e24 = (h2 & ~s[6]) | wo;
      if (rd[16:9] !== s) begin
        num_errors++;
        $display("MISMATCH rdata fields exp %h got %h", s, rd[16:9]);
      end
      if ({rd[24], psync, gin, pen, gout, ain} !== {e24, e24, e24, ~s[6], g, ea(s[5:3], h2 & ~s[6])}) begin
        num_errors++;
        $display("MISMATCH pin status exp %h got %h",
          {e24, e24, e24, ~s[6], g, ea(s[5:3], h2 & ~s[6])}, {rd[24], psync, gin, pen, gout, ain});
      end
      h2 = h1;
      h1 = pad;
    end
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
